// ---- design/esf_flag_bank.sv ----
// Error and status flag register bank of the reader front end
`timescale 1ns/1ps
`default_nettype none
`include "esf_defines.svh"
// Behaviour
// - Host FIFO write in authenticate or RF window flags misuse
// - Overheat sets flag and switches antenna drivers off
// - Command start clears errors except overheat flag
// - FIFO write while full sets overflow flag
// - Collision flag at 106 kBd, cleared at receiver start
// - CRC fail with check enabled sets flag
// - Parity fail at 106 kBd sets flag, cleared at receiver start
// - Bad start of frame at 106 kBd sets framing flag
// - Wrong byte count in authenticate sets framing flag
// - Checksum good reads one when result zero
// - Checksum done set after compute command finishes
// - Interrupt summary when any enabled source requests
// - Timer active follows run state or gating config
// - High flag when free space at most threshold
// - Low flag when level at most threshold
// - Any error flag set raises error request
// - Threshold requests latch until software clears them
// - Flush clears overflow flag and resets pointers
module esf_flag_bank
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Command and mode state
  input wire logic command_start,
  input wire logic authenticate_command,
  input wire logic checksum_compute_command,
  input wire logic rf_turnaround_window,
  input wire logic receiver_start,
  input wire esf_pkg::esf_rate_type rx_rate,
  input wire logic receive_checksum_check_enable,
  // Receiver and sensor events
  input wire logic overheat_detect,
  input wire logic overheat_clear,
  input wire logic collision_detect,
  input wire logic rx_checksum_fail,
  input wire logic parity_check_fail,
  input wire logic sof_bad,
  input wire logic auth_byte_count_bad,
  // FIFO state
  input wire logic host_fifo_write,
  input wire logic internal_fifo_write,
  input wire logic [6:0] fifo_level,
  input wire logic [5:0] fifo_threshold,
  input wire logic fifo_flush_control,
  output logic fifo_pointer_reset,
  // Coprocessor
  input wire logic crc_start,
  input wire logic crc_finish,
  input wire logic crc_result_zero,
  // Timer
  input wire logic timer_counting,
  input wire logic [1:0] timer_gating_select,
  input wire logic timer_gate_enabled,
  // Interrupt sources and clears
  input wire logic [6:0] irq_sources,
  input wire logic [6:0] irq_enables,
  input wire logic high_irq_clear,
  input wire logic low_irq_clear,
  // Flags out
  output logic [7:0] command_error_flags,
  output logic [7:0] crc_irq_fifo_status,
  output logic antenna_driver_off,
  output logic error_interrupt_request,
  output logic high_threshold_interrupt_request,
  output logic low_threshold_interrupt_request
);
  import esf_pkg::*;

  logic [7:0] err_reg, err_next;
  logic [7:0] err_set, err_clr;
  logic [7:0] rdata_reg, rdata_next;
  logic hi_irq_reg, hi_irq_next;
  logic lo_irq_reg, lo_irq_next;
  logic hi_prev_reg, hi_prev_next;
  logic lo_prev_reg, lo_prev_next;
  logic hi_event, lo_event;
  logic high_flag, low_flag;
  logic good_flag, done_flag;
  logic rate_106;
  logic fifo_full;
  logic timer_active_flag;
  logic [7:0] status_value;

  esf_threshold u_threshold
  (
    .fifo_level(fifo_level),
    .fifo_threshold(fifo_threshold),
    .fifo_high_threshold_flag(high_flag),
    .fifo_low_threshold_flag(low_flag)
  );

  esf_crc_tracker u_crc
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .crc_start(crc_start),
    .crc_finish(crc_finish),
    .crc_result_zero(crc_result_zero),
    .checksum_compute_command(checksum_compute_command),
    .checksum_good_flag(good_flag),
    .checksum_done_flag(done_flag)
  );

  // Stray codes count as a fast rate, so the base-rate-only flags stay quiet
  function automatic logic base_rate(input esf_rate_type rate);
    logic is_base;
    is_base = 1'b0;
    unique case (rate)
      ESF_RATE_106: is_base = 1'b1;
      ESF_RATE_212, ESF_RATE_HI: is_base = 1'b0;
      default: is_base = 1'b0;
    endcase
    return is_base;
  endfunction

  assign rate_106 = base_rate(rx_rate);
  assign fifo_full = (fifo_level == `ESF_FIFO_DEPTH);
  assign fifo_pointer_reset = fifo_flush_control;

  // Any nonzero gating selection is a gated mode
  function automatic logic gated_mode(input logic [1:0] select);
    logic gated;
    gated = 1'b0;
    unique case (select)
      2'b00: gated = 1'b0;
      2'b01, 2'b10, 2'b11: gated = 1'b1;
    endcase
    return gated;
  endfunction

  // Gated modes report the configured enable, never the gate pin
  assign timer_active_flag = gated_mode(timer_gating_select) ? timer_gate_enabled
                                                             : timer_counting;

  // Error flags: every bit gathers its clear and set requests separately
  always_comb
  begin
    err_clr = 8'h00;
    if (command_start)
    begin
      err_clr = ~(8'h01 << `ESF_ERR_HEAT);
    end
    if (receiver_start)
    begin
      err_clr[`ESF_ERR_COLL] = 1'b1;
      err_clr[`ESF_ERR_CRC] = 1'b1;
      err_clr[`ESF_ERR_PAR] = 1'b1;
      err_clr[`ESF_ERR_FRAME] = 1'b1;
    end
    if (fifo_flush_control)
    begin
      err_clr[`ESF_ERR_OVFL] = 1'b1;
    end
    // Only a cool sensor may drop the overheat flag; software cannot raise it
    if (overheat_clear && !overheat_detect)
    begin
      err_clr[`ESF_ERR_HEAT] = 1'b1;
    end
    // Above the base rate collisions mean nothing, so the flag is held low
    if (!rate_106)
    begin
      err_clr[`ESF_ERR_COLL] = 1'b1;
    end
    err_clr[5] = 1'b1;
  end

  always_comb
  begin
    err_set = 8'h00;
    if (host_fifo_write && (authenticate_command || rf_turnaround_window))
    begin
      err_set[`ESF_ERR_WRMIS] = 1'b1;
    end
    if (overheat_detect)
    begin
      err_set[`ESF_ERR_HEAT] = 1'b1;
    end
    // A write aimed at a full FIFO is flagged even if a flush lands with it
    if ((host_fifo_write || internal_fifo_write) && fifo_full)
    begin
      err_set[`ESF_ERR_OVFL] = 1'b1;
    end
    if (collision_detect && rate_106)
    begin
      err_set[`ESF_ERR_COLL] = 1'b1;
    end
    if (rx_checksum_fail && receive_checksum_check_enable)
    begin
      err_set[`ESF_ERR_CRC] = 1'b1;
    end
    if (parity_check_fail && rate_106)
    begin
      err_set[`ESF_ERR_PAR] = 1'b1;
    end
    if (sof_bad && rate_106)
    begin
      err_set[`ESF_ERR_FRAME] = 1'b1;
    end
    if (auth_byte_count_bad && authenticate_command)
    begin
      err_set[`ESF_ERR_FRAME] = 1'b1;
    end
  end

  // A set request outranks a clear landing in the same cycle
  always_comb
  begin
    err_next = err_set | (err_reg & ~err_clr);
  end

  // A flag that is already high when reset lifts is taken as an event
  assign hi_event = high_flag && !hi_prev_reg;
  assign lo_event = low_flag && !lo_prev_reg;

  // Threshold requests latch rising events; set wins over a software clear
  always_comb
  begin
    hi_irq_next = hi_irq_reg;
    lo_irq_next = lo_irq_reg;
    hi_prev_next = high_flag;
    lo_prev_next = low_flag;
    if (high_irq_clear)
    begin
      hi_irq_next = 1'b0;
    end
    if (low_irq_clear)
    begin
      lo_irq_next = 1'b0;
    end
    if (hi_event)
    begin
      hi_irq_next = 1'b1;
    end
    if (lo_event)
    begin
      lo_irq_next = 1'b1;
    end
  end

  always_comb
  begin
    status_value = 8'h00;
    status_value[`ESF_ST_CHECKSUM_GOOD_FLAG] = good_flag;
    status_value[`ESF_ST_CRCDONE] = done_flag;
    status_value[`ESF_ST_IRQ] = |(irq_sources & irq_enables);
    status_value[`ESF_ST_TRUN] = timer_active_flag;
    status_value[`ESF_ST_HIGH] = high_flag;
    status_value[`ESF_ST_LOW] = low_flag;
  end

  // Readback selector; unmapped offsets read as zero
  function automatic logic [7:0] readback(input logic [5:0] addr, input logic [7:0] err_value,
    input logic [7:0] stat_value);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      `ESF_ERR_OFFSET: value = err_value;
      `ESF_STAT_OFFSET: value = stat_value;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // Writes are decoded nowhere: both registers ignore the host's data
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      rdata_next = readback(reg_addr, err_reg, status_value);
    end
  end

  // Error flags keep their value until a clear request or a reset
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      err_reg <= `ESF_ERR_RESET;
    end
    else
    begin
      err_reg <= err_next;
    end
  end

  // Read data holds its last value between reads
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Requests and their edge memories
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      hi_irq_reg <= 1'b0;
      lo_irq_reg <= 1'b0;
      hi_prev_reg <= 1'b0;
      lo_prev_reg <= 1'b0;
    end
    else
    begin
      hi_irq_reg <= hi_irq_next;
      lo_irq_reg <= lo_irq_next;
      hi_prev_reg <= hi_prev_next;
      lo_prev_reg <= lo_prev_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign command_error_flags = err_reg;
  assign crc_irq_fifo_status = status_value;
  assign antenna_driver_off = err_reg[`ESF_ERR_HEAT];
  assign error_interrupt_request = |err_reg;
  assign high_threshold_interrupt_request = hi_irq_reg;
  assign low_threshold_interrupt_request = lo_irq_reg;

  // Write strobe and data only keep the port list whole; writes change nothing
  logic unused_ok;
  assign unused_ok = reg_wr ^ (^reg_wdata);
endmodule
`default_nettype wire

// ---- design/esf_defines.svh ----
// Offsets, field positions, reset values and counts of the error and status flag bank
`ifndef ESF_DEFINES_SVH
`define ESF_DEFINES_SVH
`define ESF_ERR_OFFSET 6'h06
`define ESF_STAT_OFFSET 6'h07
`define ESF_ERR_RESET 8'h00
`define ESF_STAT_RESET 8'h21
`define ESF_ERR_WRMIS 7
`define ESF_ERR_HEAT 6
`define ESF_ERR_OVFL 4
`define ESF_ERR_COLL 3
`define ESF_ERR_CRC 2
`define ESF_ERR_PAR 1
`define ESF_ERR_FRAME 0
`define ESF_ST_CHECKSUM_GOOD_FLAG 6
`define ESF_ST_CRCDONE 5
`define ESF_ST_IRQ 4
`define ESF_ST_TRUN 3
`define ESF_ST_HIGH 1
`define ESF_ST_LOW 0
`define ESF_FIFO_DEPTH 7'h40
`endif

// ---- design/esf_pkg.sv ----
// Types shared by the error and status flag bank
package esf_pkg;
  typedef enum logic [2:0] {
    ESF_RATE_106 = 3'b001,
    ESF_RATE_212 = 3'b010,
    ESF_RATE_HI = 3'b100
  } esf_rate_type;
  typedef enum logic [2:0] {
    ESF_CRC_IDLE = 3'b001,
    ESF_CRC_BUSY = 3'b010,
    ESF_CRC_DONE = 3'b100
  } esf_crc_state_type;
endpackage

// ---- design/esf_threshold.sv ----
// FIFO threshold comparators for the high and low warning flags
`timescale 1ns/1ps
`default_nettype none
`include "esf_defines.svh"
module esf_threshold
(
  // Fill state
  input wire logic [6:0] fifo_level,
  input wire logic [5:0] fifo_threshold,
  // Live flags
  output logic fifo_high_threshold_flag,
  output logic fifo_low_threshold_flag
);
  logic [6:0] free_space;
  always_comb
  begin
    free_space = `ESF_FIFO_DEPTH - fifo_level;
    fifo_high_threshold_flag = free_space <= {1'b0, fifo_threshold};
    fifo_low_threshold_flag = fifo_level <= {1'b0, fifo_threshold};
  end
endmodule
`default_nettype wire

// ---- design/esf_crc_tracker.sv ----
// Tracks the checksum coprocessor to drive the good and done status flags
`timescale 1ns/1ps
`default_nettype none
module esf_crc_tracker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Coprocessor events
  input wire logic crc_start,
  input wire logic crc_finish,
  input wire logic crc_result_zero,
  input wire logic checksum_compute_command,
  // Flags
  output logic checksum_good_flag,
  output logic checksum_done_flag
);
  import esf_pkg::*;
  esf_crc_state_type state_reg, state_next;
  logic good_reg, good_next;
  always_comb
  begin
    state_next = state_reg;
    good_next = good_reg;
    unique case (state_reg)
      ESF_CRC_IDLE, ESF_CRC_DONE:
      begin
        if (crc_start)
        begin
          state_next = ESF_CRC_BUSY;
          good_next = 1'b0;
        end
      end
      ESF_CRC_BUSY:
      begin
        if (crc_finish)
        begin
          state_next = checksum_compute_command ? ESF_CRC_DONE : ESF_CRC_IDLE;
          good_next = crc_result_zero;
        end
      end
      default:
      begin
        state_next = ESF_CRC_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_reg <= ESF_CRC_DONE;
      good_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      good_reg <= good_next;
    end
  end
  // Done only means something for the dedicated checksum command
  assign checksum_done_flag = (state_reg == ESF_CRC_DONE);
  assign checksum_good_flag = good_reg;
endmodule
`default_nettype wire

// ---- verification/esf_host_model.sv ----
// Host side model: one strobe cycle per register access
`timescale 1ns/1ps
`default_nettype none
module esf_host_model
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_rd,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // Read data is taken at the edge that samples the strobe
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_rd = !wr;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // Released lines flip so a stale address is never mistaken for a held one
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ---- verification/esf_flag_bank_asserts.sv ----
// Port-level properties of the flag bank
`timescale 1ns/1ps
`default_nettype none
module esf_flag_bank_asserts
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Inputs
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic host_fifo_write,
  input wire logic internal_fifo_write,
  input wire logic authenticate_command,
  input wire logic sof_bad,
  input wire esf_pkg::esf_rate_type rx_rate,
  input wire logic [6:0] fifo_level,
  input wire logic [5:0] fifo_threshold,
  input wire logic fifo_flush_control,
  input wire logic crc_start,
  input wire logic crc_finish,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] crc_irq_fifo_status,
  input wire logic error_interrupt_request,
  input wire logic low_threshold_interrupt_request
);
  import esf_pkg::*;
  wire logic [7:0] e = command_error_flags;
  wire logic [7:0] st = crc_irq_fifo_status;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_crc_go;
    crc_start && !crc_finish;
  endsequence
  sequence s_low_rise;
    $rose(st[0]);
  endsequence
  a_read_err: assert property (
    reg_rd && reg_addr == 6'h06 |=> reg_rdata == $past(e)) else $error("bad read data");
  a_reserved_zero: assert property (
    !e[5] && !st[7] && !st[2]) else $error("reserved bit set");
  a_misuse_set: assert property (
    host_fifo_write && authenticate_command |=> e[7]) else $error("misuse not set");
  a_sof_set: assert property (
    sof_bad && rx_rate == ESF_RATE_106 |=> e[0] && error_interrupt_request)
    else $error("framing not set");
  a_ovfl_set: assert property (
    internal_fifo_write && fifo_level == 7'h40 |=> e[4]) else $error("overflow not set");
  a_flush_clear: assert property (
    fifo_flush_control && !host_fifo_write && !internal_fifo_write |=> !e[4])
    else $error("flush kept overflow");
  a_low_live: assert property (
    st[0] == (fifo_level <= {1'b0, fifo_threshold})) else $error("low flag wrong");
  a_high_live: assert property (
    st[1] == (7'h40 - fifo_level <= {1'b0, fifo_threshold})) else $error("high flag wrong");
  a_crc_start: assert property (
    s_crc_go |=> !st[6] && !st[5]) else $error("checksum flags not cleared");
  a_low_latch: assert property (
    s_low_rise |=> low_threshold_interrupt_request) else $error("low request missed");
endmodule
bind esf_flag_bank esf_flag_bank_asserts u_chk (.*);
`default_nettype wire

// ---- verification/esf_flag_bank_tb.sv ----
// Self-checking bench for the error and status flag bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH %0t got %h exp %h", $time, a, e); \
    end \
  end
module esf_flag_bank_tb;
  import esf_pkg::*;
  logic clk_sys, srst = 1'b1, command_start = 1'b0, authenticate_command = 1'b0;
  logic checksum_compute_command = 1'b0, rf_turnaround_window = 1'b0, receiver_start = 1'b0;
  logic receive_checksum_check_enable = 1'b0, overheat_detect = 1'b0, overheat_clear = 1'b0;
  logic fifo_flush_control = 1'b0, crc_start = 1'b0, crc_finish = 1'b0, crc_result_zero = 1'b0;
  logic timer_counting = 1'b0, timer_gate_enabled = 1'b0;
  logic high_irq_clear = 1'b0, low_irq_clear = 1'b0;
  logic [1:0] timer_gating_select = 2'b00;
  logic [5:0] fifo_threshold = 6'h08, reg_addr;
  logic [6:0] fifo_level = 7'h00, irq_sources = 7'h00, irq_enables = 7'h00, ev = 7'h00;
  logic reg_rd, reg_wr, fifo_pointer_reset, antenna_driver_off, error_interrupt_request;
  logic high_threshold_interrupt_request, low_threshold_interrupt_request;
  logic [7:0] reg_wdata, reg_rdata, command_error_flags, crc_irq_fifo_status, q;
  esf_rate_type rx_rate = ESF_RATE_106;
  int n_fail, checks_done, cyc;
  wire logic sof_bad = ev[0];
  wire logic parity_check_fail = ev[1];
  wire logic rx_checksum_fail = ev[2];
  wire logic collision_detect = ev[3];
  wire logic internal_fifo_write = ev[4];
  wire logic host_fifo_write = ev[5];
  wire logic auth_byte_count_bad = ev[6];
  esf_flag_bank u_dut (.*);
  esf_host_model u_host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(logic [5:0] a);
    u_host.access(1'b0, a, 8'h00, q);
  endtask
  function automatic logic [7:0] exp_err(int i);
    return (i == 5 || i == 7) ? 8'h80 : (i == 6) ? 8'h01 : 8'h01 << i;
  endfunction
  function automatic logic [7:0] exp_stat();
    return {3'b011, |(irq_sources & irq_enables),
      timer_gating_select != 2'b00 ? timer_gate_enabled : timer_counting, 1'b0,
      7'h40 - fifo_level <= {1'b0, fifo_threshold}, fifo_level <= {1'b0, fifo_threshold}};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'hd5f4));
    tick(8);
    srst = 1'b0;
    rd(6'h06);
    `CHK(q, 8'h00)
    rd(6'h07);
    `CHK(q, 8'h21)
    rd(6'h3F);
    `CHK(q, 8'h00)
    // Pass 0 sets each flag but overheat; later passes use rates or enables that must ignore events
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < (p > 0 ? 4 : 8); i++)
      begin
        rx_rate = p == 0 ? ESF_RATE_106 : p == 1 ? ESF_RATE_212 : ESF_RATE_HI;
        receive_checksum_check_enable = p == 0;
        authenticate_command = i == 5 || i == 6;
        rf_turnaround_window = i == 7;
        fifo_level = i == 4 ? 7'h40 : 7'h00;
        command_start = 1'b1;
        tick();
        command_start = 1'b0;
        ev = 7'h01 << (i == 7 ? 5 : i);
        tick();
        ev = 7'h00;
        rd(6'h06);
        `CHK(q, p > 0 ? 8'h00 : exp_err(i))
      end
    $display("error events done");
    rx_rate = ESF_RATE_106;
    rf_turnaround_window = 1'b1;
    ev = 7'h21;
    tick();
    ev = 7'h00;
    rf_turnaround_window = 1'b0;
    receiver_start = 1'b1;
    tick();
    receiver_start = 1'b0;
    rd(6'h06);
    `CHK(q, 8'h80)
    overheat_detect = 1'b1;
    tick(2);
    `CHK(antenna_driver_off, 1'b1)
    command_start = 1'b1;
    tick();
    command_start = 1'b0;
    u_host.access(1'b1, 6'h06, 8'hFF, q);
    rd(6'h06);
    `CHK(q, 8'h40)
    overheat_detect = 1'b0;
    overheat_clear = 1'b1;
    tick();
    overheat_clear = 1'b0;
    fifo_level = 7'h40;
    ev = 7'h10;
    fifo_flush_control = 1'b1;
    #1;
    `CHK(fifo_pointer_reset, 1'b1)
    tick();
    ev = 7'h00;
    fifo_flush_control = 1'b0;
    rd(6'h06);
    `CHK(q, 8'h10)
    fifo_flush_control = 1'b1;
    tick();
    fifo_flush_control = 1'b0;
    rd(6'h06);
    `CHK(q, 8'h00)
    checksum_compute_command = 1'b1;
    crc_start = 1'b1;
    tick();
    crc_start = 1'b0;
    rd(6'h07);
    `CHK(q[6:5], 2'b00)
    crc_result_zero = 1'b1;
    crc_finish = 1'b1;
    tick();
    crc_finish = 1'b0;
    rd(6'h07);
    `CHK(q[6:5], 2'b11)
    $display("clear flush checksum done");
    for (int k = 0; k < 40; k++)
    begin
      fifo_level = 7'($urandom % 65);
      fifo_threshold = 6'($urandom);
      if (k < 4)
      begin
        fifo_level = k < 2 ? 7'h3C - 7'(k) : 7'h02 + 7'(k);
        fifo_threshold = 6'h04;
      end
      irq_sources = 7'($urandom);
      irq_enables = 7'($urandom);
      timer_counting = 1'($urandom);
      timer_gating_select = 2'($urandom);
      timer_gate_enabled = 1'($urandom);
      rd(6'h07);
      `CHK(q, exp_stat())
    end
    $display("status sweep done");
    fifo_threshold = 6'h08;
    fifo_level = 7'h14;
    high_irq_clear = 1'b1;
    low_irq_clear = 1'b1;
    tick();
    high_irq_clear = 1'b0;
    low_irq_clear = 1'b0;
    tick();
    `CHK({high_threshold_interrupt_request, low_threshold_interrupt_request}, 2'b00)
    fifo_level = 7'h00;
    tick(2);
    fifo_level = 7'h3C;
    tick(2);
    fifo_level = 7'h14;
    tick(2);
    `CHK({high_threshold_interrupt_request, low_threshold_interrupt_request}, 2'b11)
    $display("threshold requests done");
    final_report();
  end
endmodule
`default_nettype wire
